// ==== core/control_instruction_decoder.sv ====
// control-group instruction decoder top level
`timescale 1ns/1ps
//
// Contract
// - nibble 1001 is bit test, fields split
// - byte 57 tests bit chosen by treg
// - CE04 block as data, CE05 program
// - CE00 interrupts on, CE01 off
// - CE1F idles until interrupt
// - bytes 50/51 load status zero/one
// - bytes 78/79 save status zero/one
// - 5500 is a one-word no-op
// - CE1C push accumulator, CE1D pop
// - byte 54 push memory, 7A pop
// - CE30 clears carry, CE31 sets
// - CE38 clears hold flag, CE39 sets
// - CE02 clears saturation, CE03 sets
// - CE06 clears sign extension, CE07 sets
// - CE32 clears test flag, CE33 sets
// - byte 4B repeat memory, CB immediate
// - CE1E is software trap
// - machine clock is oscillator over four
module control_instruction_decoder
    import ctl_decode_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [WORD_W-1:0] INSTR_WORD,
    input wire logic INSTR_VALID,
    output logic DEC_VALID,
    output op_type DEC_OP,
    output logic IS_CONTROL,
    output logic OUTSIDE_GROUP,
    output logic MEM_REF,
    output logic MODE_FLAG,
    output logic [ADDR_W-1:0] DIRECT_ADDR,
    output logic [BITSEL_W-1:0] BIT_SELECT,
    output logic BIT_FROM_TREG,
    output logic [IMM_W-1:0] REPEAT_COUNT,
    output logic REPEAT_FROM_MEM,
    output logic INTERRUPTS_ON,
    output logic INTERRUPTS_OFF,
    output logic IDLE_REQ,
    output logic TRAP_REQ,
    output logic BLOCK_AS_PROGRAM,
    output logic BLOCK_CFG_STROBE,
    output logic STACK_PUSH,
    output logic STACK_POP,
    output logic FLAG_STROBE,
    output logic MACHINE_CLOCK_PHASE_A,
    output logic MACHINE_PHASE_START
);
    op_type op;
    logic in_ce_group;
    logic has_mem_ref;
    logic known;

    // decode helpers shared by the pulse registers and the block configuration strobe
    function automatic logic pulse_for(
        input logic valid,
        input op_type o,
        input op_type want
    );
        pulse_for = valid && (o == want);
    endfunction : pulse_for

    function automatic logic pair_for(
        input logic valid,
        input op_type o,
        input op_type first,
        input op_type second
    );
        pair_for = valid && (o == first || o == second);
    endfunction : pair_for

    // refuse a package edit that the fixed word layout cannot serve
    if (WORD_W != 16) begin : gen_word_check
        $error("instruction word must be sixteen bits");
    end
    if (ADDR_W != MODE_BIT) begin : gen_addr_check
        $error("address field must end just below the mode bit");
    end
    if (BITSEL_LSB + BITSEL_W > TOP_NIB_LSB) begin : gen_bitsel_check
        $error("bit select overlaps the top nibble");
    end
    if (IMM_W > HI_BYTE_LSB) begin : gen_imm_check
        $error("repeat count overlaps the upper byte");
    end
    if (CLK_DIV != 4) begin : gen_div_check
        $error("machine clock divider is built for four");
    end

    // one decode shared by the op-based output registers below; valid and field registers take the word directly
    ctl_word_classify u_classify (
        .word(INSTR_WORD),
        .op(op),
        .in_ce_group(in_ce_group),
        .has_mem_ref(has_mem_ref)
    );

    assign known = (op != OP_NONE);

    // derived machine clock, a quarter of the input rate
    machine_clock_div u_clock_div (
        .clk(CLK),
        .srst(SRST),
        .phase_clk(MACHINE_CLOCK_PHASE_A),
        .phase_start(MACHINE_PHASE_START)
    );

    // decoded valid, one cycle after the word
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DEC_VALID <= 1'b0;
        end else begin
            DEC_VALID <= INSTR_VALID;
        end
    end

    // decoded op; idle cycles read as OP_NONE so the core never repeats one
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DEC_OP <= OP_NONE;
        end else begin
            DEC_OP <= INSTR_VALID ? op : OP_NONE;
        end
    end

    // listed control op seen
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IS_CONTROL <= 1'b0;
        end else begin
            IS_CONTROL <= INSTR_VALID && known;
        end
    end

    // hand unknown CE-group words to the illegal-op path
    always_ff @(posedge CLK) begin
        if (SRST) begin
            OUTSIDE_GROUP <= 1'b0;
        end else begin
            OUTSIDE_GROUP <= INSTR_VALID && in_ce_group && !known;
        end
    end

    // memory reference field in use; repeat immediate has none
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_REF <= 1'b0;
        end else begin
            MEM_REF <= INSTR_VALID && has_mem_ref;
        end
    end

    // addressing-mode bit; fields hold their last value when idle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MODE_FLAG <= 1'b0;
        end else if (INSTR_VALID) begin
            MODE_FLAG <= INSTR_WORD[MODE_BIT];
        end
    end

    // direct address field
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DIRECT_ADDR <= '0;
        end else if (INSTR_VALID) begin
            DIRECT_ADDR <= INSTR_WORD[ADDR_W-1:0];
        end
    end

    // tested bit number
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BIT_SELECT <= '0;
        end else if (INSTR_VALID) begin
            BIT_SELECT <= INSTR_WORD[BITSEL_LSB +: BITSEL_W];
        end
    end

    // immediate repeat count; only meaningful with repeat immediate
    always_ff @(posedge CLK) begin
        if (SRST) begin
            REPEAT_COUNT <= '0;
        end else if (INSTR_VALID) begin
            REPEAT_COUNT <= INSTR_WORD[IMM_W-1:0];
        end
    end

    // bit number taken from the multiplier operand register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BIT_FROM_TREG <= 1'b0;
        end else begin
            BIT_FROM_TREG <= pulse_for(INSTR_VALID, op,
                OP_TEST_TREG_BIT);
        end
    end

    // repeat count taken from data memory
    always_ff @(posedge CLK) begin
        if (SRST) begin
            REPEAT_FROM_MEM <= 1'b0;
        end else begin
            REPEAT_FROM_MEM <= pulse_for(INSTR_VALID, op,
                OP_REPEAT_MEM);
        end
    end

    // interrupt enable request, one cycle per valid word
    always_ff @(posedge CLK) begin
        if (SRST) begin
            INTERRUPTS_ON <= 1'b0;
        end else begin
            INTERRUPTS_ON <= pulse_for(INSTR_VALID, op,
                OP_INTERRUPTS_ON);
        end
    end

    // interrupt disable request
    always_ff @(posedge CLK) begin
        if (SRST) begin
            INTERRUPTS_OFF <= 1'b0;
        end else begin
            INTERRUPTS_OFF <= pulse_for(INSTR_VALID, op,
                OP_INTERRUPTS_OFF);
        end
    end

    // idle request; the core holds off fetch until an interrupt
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IDLE_REQ <= 1'b0;
        end else begin
            IDLE_REQ <= pulse_for(INSTR_VALID, op,
                OP_IDLE);
        end
    end

    // software trap request
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TRAP_REQ <= 1'b0;
        end else begin
            TRAP_REQ <= pulse_for(INSTR_VALID, op,
                OP_SOFT_TRAP);
        end
    end

    // memory block configuration strobe, either direction
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BLOCK_CFG_STROBE <= 1'b0;
        end else begin
            BLOCK_CFG_STROBE <= pair_for(INSTR_VALID, op, OP_BLOCK_AS_DATA,
                OP_BLOCK_AS_PROGRAM);
        end
    end

    // block setting level that the core applies on the strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BLOCK_AS_PROGRAM <= 1'b0;
        end else begin
            if (INSTR_VALID && op == OP_BLOCK_AS_PROGRAM) begin
                BLOCK_AS_PROGRAM <= 1'b1;
            end else if (INSTR_VALID && op == OP_BLOCK_AS_DATA) begin
                BLOCK_AS_PROGRAM <= 1'b0;
            end
        end
    end

    // stack push pulse; DEC_OP tells accumulator or memory side
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STACK_PUSH <= 1'b0;
        end else begin
            STACK_PUSH <= pair_for(INSTR_VALID, op, OP_PUSH_ACC,
                OP_STACK_PUSH_MEM);
        end
    end

    // stack pop pulse
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STACK_POP <= 1'b0;
        end else begin
            STACK_POP <= pair_for(INSTR_VALID, op, OP_POP_ACC,
                OP_STACK_POP_MEM);
        end
    end

    // mode flag writes: the core takes the flag and value from DEC_OP
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FLAG_STROBE <= 1'b0;
        end else begin
            case (op)
                OP_CLEAR_CARRY, OP_SET_CARRY,
                OP_CLEAR_HOLD, OP_SET_HOLD,
                OP_CLEAR_SATURATION, OP_SET_SATURATION,
                OP_CLEAR_SIGNEXT, OP_SET_SIGNEXT,
                OP_CLEAR_TEST, OP_SET_TEST: begin
                    FLAG_STROBE <= INSTR_VALID;
                end
                default: begin
                    // no-op and the rest touch no flag
                    FLAG_STROBE <= 1'b0;
                end
            endcase
        end
    end
endmodule : control_instruction_decoder

// ==== include/ctl_decode_pkg.sv ====
// constants and types shared by the control-group decoder files
package ctl_decode_pkg;
    localparam int WORD_W = 16;
    // fixed full-word encodings
    localparam logic [15:0] OPC_INTERRUPTS_ON = 16'hCE00;
    localparam logic [15:0] OPC_INTERRUPTS_OFF = 16'hCE01;
    localparam logic [15:0] OPC_CLEAR_SATURATION = 16'hCE02;
    localparam logic [15:0] OPC_SET_SATURATION = 16'hCE03;
    localparam logic [15:0] OPC_BLOCK_AS_DATA = 16'hCE04;
    localparam logic [15:0] OPC_BLOCK_AS_PROGRAM = 16'hCE05;
    localparam logic [15:0] OPC_CLEAR_SIGNEXT = 16'hCE06;
    localparam logic [15:0] OPC_SET_SIGNEXT = 16'hCE07;
    localparam logic [15:0] OPC_PUSH_ACC = 16'hCE1C;
    localparam logic [15:0] OPC_POP_ACC = 16'hCE1D;
    localparam logic [15:0] OPC_SOFT_TRAP = 16'hCE1E;
    localparam logic [15:0] OPC_IDLE = 16'hCE1F;
    localparam logic [15:0] OPC_CLEAR_CARRY = 16'hCE30;
    localparam logic [15:0] OPC_SET_CARRY = 16'hCE31;
    localparam logic [15:0] OPC_CLEAR_TEST = 16'hCE32;
    localparam logic [15:0] OPC_SET_TEST = 16'hCE33;
    localparam logic [15:0] OPC_CLEAR_HOLD = 16'hCE38;
    localparam logic [15:0] OPC_SET_HOLD = 16'hCE39;
    localparam logic [15:0] OPC_NO_OP = 16'h5500;
    // upper-byte and top-nibble encodings
    localparam logic [7:0] HI_CONTROL_GROUP = 8'hCE;
    localparam logic [7:0] HI_TEST_TREG_BIT = 8'h57;
    localparam logic [7:0] HI_LOAD_STATUS_ZERO = 8'h50;
    localparam logic [7:0] HI_LOAD_STATUS_ONE = 8'h51;
    localparam logic [7:0] HI_SAVE_STATUS_ZERO = 8'h78;
    localparam logic [7:0] HI_SAVE_STATUS_ONE = 8'h79;
    localparam logic [7:0] HI_STACK_PUSH_MEM = 8'h54;
    localparam logic [7:0] HI_STACK_POP_MEM = 8'h7A;
    localparam logic [7:0] HI_REPEAT_MEM = 8'h4B;
    localparam logic [7:0] HI_REPEAT_IMM = 8'hCB;
    localparam logic [3:0] NIB_TEST_BIT = 4'h9;
    // field positions
    localparam int TOP_NIB_LSB = 12;
    localparam int HI_BYTE_LSB = 8;
    localparam int BITSEL_LSB = 8;
    localparam int MODE_BIT = 7;
    localparam int ADDR_W = 7;
    localparam int BITSEL_W = 4;
    localparam int IMM_W = 8;
    // machine clock: oscillator divided by four
    localparam int CLK_DIV = 4;

    typedef enum logic [4:0] {
        OP_NONE, OP_TEST_BIT, OP_TEST_TREG_BIT, OP_BLOCK_AS_DATA,
        OP_BLOCK_AS_PROGRAM, OP_INTERRUPTS_ON, OP_INTERRUPTS_OFF, OP_IDLE,
        OP_LOAD_STATUS_ZERO, OP_LOAD_STATUS_ONE, OP_SAVE_STATUS_ZERO,
        OP_SAVE_STATUS_ONE, OP_NO_OP, OP_PUSH_ACC, OP_POP_ACC,
        OP_STACK_PUSH_MEM, OP_STACK_POP_MEM, OP_CLEAR_CARRY, OP_SET_CARRY,
        OP_CLEAR_HOLD, OP_SET_HOLD, OP_CLEAR_SATURATION, OP_SET_SATURATION,
        OP_CLEAR_SIGNEXT, OP_SET_SIGNEXT, OP_CLEAR_TEST, OP_SET_TEST,
        OP_REPEAT_MEM, OP_REPEAT_IMM, OP_SOFT_TRAP
    } op_type;
endpackage : ctl_decode_pkg

// ==== core/ctl_word_classify.sv ====
// combinational classification of one instruction word
`timescale 1ns/1ps
module ctl_word_classify
    import ctl_decode_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    output op_type op,
    output logic in_ce_group,
    output logic has_mem_ref
);
    logic [7:0] hi;
    assign hi = word[HI_BYTE_LSB +: 8];
    assign in_ce_group = (hi == HI_CONTROL_GROUP);

    // full-word encodings first, then upper-byte and nibble formats
    always_comb begin
        op = OP_NONE;
        has_mem_ref = 1'b0;
        case (word)
            OPC_BLOCK_AS_DATA: op = OP_BLOCK_AS_DATA;
            OPC_BLOCK_AS_PROGRAM: op = OP_BLOCK_AS_PROGRAM;
            OPC_INTERRUPTS_ON: op = OP_INTERRUPTS_ON;
            OPC_INTERRUPTS_OFF: op = OP_INTERRUPTS_OFF;
            OPC_IDLE: op = OP_IDLE;
            OPC_NO_OP: op = OP_NO_OP;
            OPC_PUSH_ACC: op = OP_PUSH_ACC;
            OPC_POP_ACC: op = OP_POP_ACC;
            OPC_CLEAR_CARRY: op = OP_CLEAR_CARRY;
            OPC_SET_CARRY: op = OP_SET_CARRY;
            OPC_CLEAR_HOLD: op = OP_CLEAR_HOLD;
            OPC_SET_HOLD: op = OP_SET_HOLD;
            OPC_CLEAR_SATURATION: op = OP_CLEAR_SATURATION;
            OPC_SET_SATURATION: op = OP_SET_SATURATION;
            OPC_CLEAR_SIGNEXT: op = OP_CLEAR_SIGNEXT;
            OPC_SET_SIGNEXT: op = OP_SET_SIGNEXT;
            OPC_CLEAR_TEST: op = OP_CLEAR_TEST;
            OPC_SET_TEST: op = OP_SET_TEST;
            OPC_SOFT_TRAP: op = OP_SOFT_TRAP;
            default: begin
                has_mem_ref = 1'b1;
                case (hi)
                    HI_TEST_TREG_BIT: op = OP_TEST_TREG_BIT;
                    HI_LOAD_STATUS_ZERO: op = OP_LOAD_STATUS_ZERO;
                    HI_LOAD_STATUS_ONE: op = OP_LOAD_STATUS_ONE;
                    HI_SAVE_STATUS_ZERO: op = OP_SAVE_STATUS_ZERO;
                    HI_SAVE_STATUS_ONE: op = OP_SAVE_STATUS_ONE;
                    HI_STACK_PUSH_MEM: op = OP_STACK_PUSH_MEM;
                    HI_STACK_POP_MEM: op = OP_STACK_POP_MEM;
                    HI_REPEAT_MEM: op = OP_REPEAT_MEM;
                    HI_REPEAT_IMM: begin
                        op = OP_REPEAT_IMM;
                        has_mem_ref = 1'b0;
                    end
                    default: begin
                        if (word[TOP_NIB_LSB +: 4] == NIB_TEST_BIT) begin
                            op = OP_TEST_BIT;
                        end else begin
                            op = OP_NONE;
                            has_mem_ref = 1'b0;
                        end
                    end
                endcase
            end
        endcase
    end
endmodule : ctl_word_classify

// ==== core/machine_clock_div.sv ====
// divide-by-four machine clock phase generator
`timescale 1ns/1ps
module machine_clock_div
    import ctl_decode_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    output logic phase_clk,
    output logic phase_start
);
    logic [1:0] count;

    // free-running count; output high for the first half of four cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    // registered so the divided clock carries no decode glitches
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_clk <= 1'b0;
            phase_start <= 1'b0;
        end else begin
            phase_clk <= (count < 2'(CLK_DIV / 2));
            phase_start <= (count == 2'h0);
        end
    end
endmodule : machine_clock_div

// ==== testbench/control_instruction_decoder_properties.sv ====
// assertion checker watching the control-group decoder ports
`timescale 1ns/1ps
module control_instruction_decoder_properties
    import ctl_decode_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [WORD_W-1:0] INSTR_WORD,
    input wire logic INSTR_VALID,
    input wire logic DEC_VALID,
    input wire op_type DEC_OP,
    input wire logic OUTSIDE_GROUP,
    input wire logic MEM_REF,
    input wire logic [BITSEL_W-1:0] BIT_SELECT,
    input wire logic [IMM_W-1:0] REPEAT_COUNT,
    input wire logic BLOCK_AS_PROGRAM,
    input wire logic BLOCK_CFG_STROBE,
    input wire logic FLAG_STROBE,
    input wire logic INTERRUPTS_ON,
    input wire logic INTERRUPTS_OFF,
    input wire logic IDLE_REQ,
    input wire logic TRAP_REQ,
    input wire logic MACHINE_CLOCK_PHASE_A,
    input wire logic MACHINE_PHASE_START
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // machine clock halves, two cycles each
    sequence phase_high;
        MACHINE_CLOCK_PHASE_A [*2];
    endsequence
    sequence phase_low;
        !MACHINE_CLOCK_PHASE_A [*2];
    endsequence
    chk_answer_next: assert property (INSTR_VALID |=> DEC_VALID)
        else $error("decoded valid missing");
    chk_carry_set: assert property (INSTR_VALID && INSTR_WORD ==
        OPC_SET_CARRY |=> DEC_OP == OP_SET_CARRY && FLAG_STROBE)
        else $error("carry set not decoded");
    chk_bit_fields: assert property (INSTR_VALID &&
        INSTR_WORD[15:12] == NIB_TEST_BIT |=> DEC_OP == OP_TEST_BIT
        && MEM_REF && BIT_SELECT == $past(INSTR_WORD[11:8]))
        else $error("bit test fields wrong");
    chk_repeat_count: assert property (INSTR_VALID &&
        INSTR_WORD[15:8] == HI_REPEAT_IMM |=> DEC_OP == OP_REPEAT_IMM
        && REPEAT_COUNT == $past(INSTR_WORD[7:0]))
        else $error("repeat count wrong");
    chk_outside_none: assert property (OUTSIDE_GROUP |->
        DEC_OP == OP_NONE && $past(INSTR_WORD[15:8]) == HI_CONTROL_GROUP)
        else $error("outside flag on wrong word");
    chk_block_select: assert property (BLOCK_CFG_STROBE |->
        $past(INSTR_VALID) && BLOCK_AS_PROGRAM == $past(INSTR_WORD[0]))
        else $error("block setting wrong");
    chk_idle_only: assert property (INSTR_VALID &&
        INSTR_WORD == OPC_IDLE |=> IDLE_REQ && !TRAP_REQ)
        else $error("idle not decoded");
    chk_irq_enable: assert property (INSTR_VALID &&
        INSTR_WORD == OPC_INTERRUPTS_ON |=> INTERRUPTS_ON && !INTERRUPTS_OFF)
        else $error("interrupt enable not decoded");
    chk_phase_period: assert property (MACHINE_PHASE_START |=>
        !MACHINE_PHASE_START [*3] ##1 MACHINE_PHASE_START)
        else $error("phase start period wrong");
    chk_phase_shape: assert property (MACHINE_PHASE_START |->
        phase_high ##1 phase_low)
        else $error("machine clock duty wrong");
endmodule : control_instruction_decoder_properties

bind control_instruction_decoder control_instruction_decoder_properties
    control_instruction_decoder_properties_inst (
    .CLK(CLK), .SRST(SRST), .INSTR_WORD(INSTR_WORD),
    .INSTR_VALID(INSTR_VALID), .DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP),
    .OUTSIDE_GROUP(OUTSIDE_GROUP), .MEM_REF(MEM_REF),
    .BIT_SELECT(BIT_SELECT), .REPEAT_COUNT(REPEAT_COUNT),
    .BLOCK_AS_PROGRAM(BLOCK_AS_PROGRAM), .BLOCK_CFG_STROBE(BLOCK_CFG_STROBE),
    .FLAG_STROBE(FLAG_STROBE), .INTERRUPTS_ON(INTERRUPTS_ON),
    .INTERRUPTS_OFF(INTERRUPTS_OFF), .IDLE_REQ(IDLE_REQ),
    .TRAP_REQ(TRAP_REQ), .MACHINE_CLOCK_PHASE_A(MACHINE_CLOCK_PHASE_A),
    .MACHINE_PHASE_START(MACHINE_PHASE_START)
);

// ==== testbench/prog_word_source.sv ====
// program memory side handing instruction words to the decoder
`timescale 1ns/1ps
module prog_word_source (
    input wire logic clk,
    input wire logic fetch,
    input wire logic [15:0] fetch_word,
    output logic [15:0] word,
    output logic valid
);
    logic [15:0] last = 16'h0000;
    // remember the last word so a released bus never repeats it
    always @(posedge clk) begin
        if (fetch) begin
            last <= fetch_word;
        end
    end
    // released bus shows the inverse, so stale data cannot pass
    assign word = fetch ? fetch_word : ~last;
    assign valid = fetch;
endmodule : prog_word_source

// ==== testbench/control_instruction_decoder_test.sv ====
// self-checking bench for the control-group decoder
`timescale 1ns/1ps
module control_instruction_decoder_test;
    import ctl_decode_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic fetch = 1'b0;
    logic [15:0] fw = 16'h0000;
    logic [15:0] iw;
    logic iv, dv, ctl, outg, mref, mode, btreg, rmem, ion, ioff, idle, trap;
    logic bprog, bstb, push, pop, fstb, pha, phs, blk;
    op_type op;
    logic [6:0] addr;
    logic [3:0] bsel;
    logic [7:0] rcnt;
    int n_fail = 0;
    int total_checks = 0;
    int i, n, m;
    // table of words and the op each must decode to
    logic [15:0] words [31] = '{16'hCE00, 16'hCE01, 16'hCE02, 16'hCE03,
        16'hCE04, 16'hCE05, 16'hCE06, 16'hCE07, 16'hCE1C, 16'hCE1D,
        16'hCE1E, 16'hCE1F, 16'hCE30, 16'hCE31, 16'hCE32, 16'hCE33,
        16'hCE38, 16'hCE39, 16'h5500, 16'h9A85, 16'h57C3, 16'h5012,
        16'h5181, 16'h7834, 16'h79F5, 16'h5466, 16'h7AFF, 16'h4B80,
        16'hCBFF, 16'hCE40, 16'h1234};
    op_type ops [31] = '{OP_INTERRUPTS_ON, OP_INTERRUPTS_OFF,
        OP_CLEAR_SATURATION, OP_SET_SATURATION, OP_BLOCK_AS_DATA,
        OP_BLOCK_AS_PROGRAM, OP_CLEAR_SIGNEXT, OP_SET_SIGNEXT, OP_PUSH_ACC,
        OP_POP_ACC, OP_SOFT_TRAP, OP_IDLE, OP_CLEAR_CARRY, OP_SET_CARRY,
        OP_CLEAR_TEST, OP_SET_TEST, OP_CLEAR_HOLD, OP_SET_HOLD, OP_NO_OP,
        OP_TEST_BIT, OP_TEST_TREG_BIT, OP_LOAD_STATUS_ZERO,
        OP_LOAD_STATUS_ONE, OP_SAVE_STATUS_ZERO, OP_SAVE_STATUS_ONE,
        OP_STACK_PUSH_MEM, OP_STACK_POP_MEM, OP_REPEAT_MEM, OP_REPEAT_IMM,
        OP_NONE, OP_NONE};
    // 40 MHz clock
    always #12.5 clk = ~clk;
    prog_word_source prog_word_source_inst (.clk(clk), .fetch(fetch),
        .fetch_word(fw), .word(iw), .valid(iv));
    control_instruction_decoder control_instruction_decoder_inst (
        .CLK(clk), .SRST(srst), .INSTR_WORD(iw), .INSTR_VALID(iv),
        .DEC_VALID(dv), .DEC_OP(op), .IS_CONTROL(ctl), .OUTSIDE_GROUP(outg),
        .MEM_REF(mref), .MODE_FLAG(mode), .DIRECT_ADDR(addr),
        .BIT_SELECT(bsel), .BIT_FROM_TREG(btreg), .REPEAT_COUNT(rcnt),
        .REPEAT_FROM_MEM(rmem), .INTERRUPTS_ON(ion), .INTERRUPTS_OFF(ioff),
        .IDLE_REQ(idle), .TRAP_REQ(trap), .BLOCK_AS_PROGRAM(bprog),
        .BLOCK_CFG_STROBE(bstb), .STACK_PUSH(push), .STACK_POP(pop),
        .FLAG_STROBE(fstb), .MACHINE_CLOCK_PHASE_A(pha),
        .MACHINE_PHASE_START(phs));
    task automatic check(input string name, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // step past the edge so its updates have landed
    task automatic tick;
        @(posedge clk);
        #2;
    endtask : tick
    // compare every output except the machine clock pair for one accepted word
    task automatic expect_word(input logic [15:0] w, input op_type o);
        if (o == OP_BLOCK_AS_DATA) blk = 1'b0;
        if (o == OP_BLOCK_AS_PROGRAM) blk = 1'b1;
        check("valid", 16'(dv), 16'h0001);
        check("op", 16'(op), 16'(o));
        check("control", 16'(ctl), 16'(o != OP_NONE));
        check("outside", 16'(outg), 16'(w[15:8] == HI_CONTROL_GROUP
            && o == OP_NONE));
        check("flag", 16'(fstb), 16'(o >= OP_CLEAR_CARRY
            && o <= OP_SET_TEST));
        check("irq", 16'({ion, ioff, idle, trap}), 16'({o == OP_INTERRUPTS_ON,
            o == OP_INTERRUPTS_OFF, o == OP_IDLE, o == OP_SOFT_TRAP}));
        check("stack", 16'({push, pop}), 16'({o == OP_PUSH_ACC ||
            o == OP_STACK_PUSH_MEM, o == OP_POP_ACC
            || o == OP_STACK_POP_MEM}));
        check("mem ref", 16'(mref), 16'(o inside {OP_TEST_BIT,
            OP_TEST_TREG_BIT, OP_LOAD_STATUS_ZERO, OP_LOAD_STATUS_ONE,
            OP_SAVE_STATUS_ZERO, OP_SAVE_STATUS_ONE, OP_STACK_PUSH_MEM,
            OP_STACK_POP_MEM, OP_REPEAT_MEM}));
        check("block strobe", 16'(bstb), 16'(o == OP_BLOCK_AS_DATA
            || o == OP_BLOCK_AS_PROGRAM));
        check("source", 16'({btreg, rmem}), 16'({o == OP_TEST_TREG_BIT,
            o == OP_REPEAT_MEM}));
        check("block", 16'(bprog), 16'(blk));
        check("fields", 16'({bsel, mode, addr}), 16'(w[11:0]));
        check("count", 16'(rcnt), 16'(w[7:0]));
    endtask : expect_word
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // cuts a hang short after far more than the tests need
    initial begin
        #25000;
        n_fail++;
        $display("watchdog expired");
        final_report;
    end
    initial begin
        blk = 1'b0;
        repeat (8) tick;
        srst = 1'b0;
        // every listed word back to back, answered one cycle later
        fetch = 1'b1;
        fw = words[0];
        for (i = 1; i <= 31; i++) begin
            tick;
            expect_word(words[i-1], ops[i-1]);
            if (i < 31) fw = words[i];
            else fetch = 1'b0;
        end
        $display("test decode table done");
        tick;
        check("idle valid", 16'(dv), 16'h0000);
        check("idle op", 16'(op), 16'(OP_NONE));
        fetch = 1'b1;
        fw = OPC_SET_HOLD;
        repeat (2) begin
            tick;
            check("held strobe", 16'(fstb), 16'h0001);
        end
        fetch = 1'b0;
        $display("test held word done");
        n = 0;
        m = 0;
        repeat (40) begin
            tick;
            n += phs;
            m += pha;
        end
        check("phase starts", 16'(n), 16'h000A);
        check("phase high", 16'(m), 16'h0014);
        $display("test machine clock done");
        srst = 1'b1;
        repeat (2) tick;
        check("reset block", 16'(bprog), 16'h0000);
        srst = 1'b0;
        tick;
        check("first phase", 16'({pha, phs}), 16'h0003);
        $display("test reset done");
        final_report;
    end
endmodule : control_instruction_decoder_test
